// file: common/odcc_pkg.sv
package odcc_pkg;
   // Command opcodes
   localparam logic [7:0] CMD_REF_CURRENT = 8'h82;
   localparam logic [7:0] CMD_REMAP       = 8'hA0;
   localparam logic [7:0] CMD_PAD_LAYOUT  = 8'hA2;
   localparam logic [7:0] CMD_ALL_ON      = 8'hA4;
   localparam logic [7:0] CMD_INVERT      = 8'hA6;
   localparam logic [7:0] CMD_MUX         = 8'hA8;
   localparam logic [7:0] CMD_DCDC        = 8'hAD;
   localparam logic [7:0] CMD_DISPLAY     = 8'hAE;
   localparam logic [7:0] DCDC_PARAM      = 8'h8A;
   // Masks that drop the low select bit
   localparam logic [7:0] MASK_LOW_BIT    = 8'hFE;
   // Parameter byte field positions
   localparam int TRIM_EN_BIT  = 7;
   localparam int REF_SRC_BIT  = 2;
   localparam int RES_CODE_HI  = 1;
   localparam int MUX_HI       = 5;
   localparam int PAD_DIR_BIT  = 6;
   localparam int PAD_STEP_HI  = 5;
   localparam int PAD_STEP_LO  = 2;
   // Reset values
   localparam logic       TRIM_EN_RST  = 1'b0;
   localparam logic       REF_SRC_RST  = 1'b0;
   localparam logic [1:0] RES_CODE_RST = 2'h0;
   localparam logic [5:0] MUX_RST      = 6'h3F;
   localparam logic       DCDC_RST     = 1'b1;
   localparam logic [6:0] COL_RST      = 7'h00;
   localparam logic [3:0] STEP_ALL     = 4'hF;
   // Resistor values in kilohm per code
   localparam logic [9:0] RES_K0 = 10'd510;
   localparam logic [9:0] RES_K1 = 10'd310;
   localparam logic [9:0] RES_K2 = 10'd220;
   localparam logic [9:0] RES_K3 = 10'd180;
   localparam logic [3:0] STEP_PCT = 4'h3;
   // Decoder states
   typedef enum logic [1:0] {
      ODCC_IDLE = 2'b00,
      ODCC_REF  = 2'b01,
      ODCC_MUX  = 2'b11,
      ODCC_DCDC = 2'b10
   } odcc_state_t;
endpackage : odcc_pkg

// file: common/odcc_trim_if.sv
`timescale 1ns/10ps
interface odcc_trim_if;
   logic       trimOn;
   logic [4:0] padCode;
   logic       down;
   logic [5:0] pct;
   modport ctrl (output trimOn, output padCode, input down, input pct);
   modport calc (input trimOn, input padCode, output down, output pct);
endinterface : odcc_trim_if

// file: src/odcc_config.sv
// Operation
// - 82H opens two-byte command: bit7 trim enable, bit2 source, bits1:0 code
// - Source bit low selects external resistor, high internal
// - Resistor code 00=510k, 01=310k, 10=220k, 11=180k
// - Trim enable low keeps pad trimming off, high enables it
// - Pad D6 direction, D5..D2 steps of 3%, down all-ones gives 0%
// - Parallel host interface forces trimming off
// - A0H/A1H set column reverse from bit 0
// - Column address advances by one after each data access
// - A2H/A3H set segment pad layout from bit 0
// - A4H/A5H force all pixels on, RAM untouched
// - Force-all-on overrides normal/reverse display
// - A6H/A7H inversion bit, RAM never rewritten
// - A8H then bits5:0 give multiplex N+1, 64 at reset
// - ADH then 8AH/8BH, bit 0 is converter enable
// - Converter enable high starts converter when display on
// - Display off sleeps; on uses converter or external supply
// - AEH/AFH display switch, off at reset, off means power save

`timescale 1ns/10ps
module odcc_config (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Host byte stream, same clock domain, plus the parallelHost strap pin that is synchronised
   input  wire logic       byteValid,
   input  wire logic [7:0] byteData,
   input  wire logic       dataSel,
   input  wire logic       dataAccess,
   input  wire logic       parallelHost,
   // Data pads used for trimming
   input  wire logic [4:0] trimPads,
   // Configuration outputs
   output logic            refCurrentInternal,
   output logic [1:0]      resistorCode,
   output logic [9:0]      resistorKohm,
   output logic            trimActive,
   output logic            trimDown,
   output logic [5:0]      trimPercent,
   output logic            columnReverse,
   output logic            padsEvenRight,
   output logic            forceAllOn,
   output logic            invertDisplay,
   output logic [6:0]      muxRatio,
   output logic            converterEnable,
   output logic            displayOn,
   output logic            sleepMode,
   output logic            converterRun,
   output logic            externalSupply,
   output logic            pixelForceOn,
   output logic            pixelInvert,
   output logic [6:0]      columnAddr
);
   // Pin inputs pass two flops before use
   logic [4:0] padMeta;
   logic [4:0] padSync;
   logic       parMeta;
   logic       parSync;

   // Configuration state and next values
   odcc_pkg::odcc_state_t state;
   odcc_pkg::odcc_state_t next_state;
   logic       trimEn;
   logic       next_trimEn;
   logic       next_refCurrentInternal;
   logic [1:0] next_resistorCode;
   logic       next_columnReverse;
   logic       next_padsEvenRight;
   logic       next_forceAllOn;
   logic       next_invertDisplay;
   logic [5:0] muxN;
   logic [5:0] next_muxN;
   logic       next_converterEnable;
   logic       next_displayOn;
   logic [6:0] next_columnAddr;
   logic [9:0] next_resistorKohm;
   logic       next_trimActive;
   logic       next_trimDown;
   logic [5:0] next_trimPercent;
   logic       cmdByte;

   // Derived mode next values
   logic [6:0] next_muxRatio;
   logic       next_sleepMode;
   logic       next_converterRun;
   logic       next_externalSupply;
   logic       next_pixelForceOn;
   logic       next_pixelInvert;

   // Link to the pad trim calculator
   odcc_trim_if trim ();

   // Pad code to signed percent, purely combinational
   odcc_trim_calc u_trim (
      .t (trim.calc)
   );

   // Pad synchroniser; pads move freely against mclk
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         padMeta <= 5'h00;
         padSync <= 5'h00;
      end else begin
         padMeta <= trimPads;
         padSync <= padMeta;
      end
   end

   // Host-mode strap synchroniser; the strap is a pin like the pads
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         parMeta <= 1'b0;
         parSync <= 1'b0;
      end else begin
         parMeta <= parallelHost;
         parSync <= parMeta;
      end
   end

   // Data bytes belong to the RAM path and never reach the decoder
   assign cmdByte = byteValid && !dataSel;

   // Command decoder and setting updates
   always_comb begin
      next_state              = state;
      next_trimEn             = trimEn;
      next_refCurrentInternal = refCurrentInternal;
      next_resistorCode       = resistorCode;
      next_columnReverse      = columnReverse;
      next_padsEvenRight      = padsEvenRight;
      next_forceAllOn         = forceAllOn;
      next_invertDisplay      = invertDisplay;
      next_muxN               = muxN;
      next_converterEnable    = converterEnable;
      next_displayOn          = displayOn;
      if (cmdByte) begin
         case (state)
            odcc_pkg::ODCC_REF: begin
               next_trimEn             = byteData[odcc_pkg::TRIM_EN_BIT];
               next_refCurrentInternal = byteData[odcc_pkg::REF_SRC_BIT];
               next_resistorCode       = byteData[odcc_pkg::RES_CODE_HI:0];
               next_state              = odcc_pkg::ODCC_IDLE;
            end
            odcc_pkg::ODCC_MUX: begin
               next_muxN  = byteData[odcc_pkg::MUX_HI:0];
               next_state = odcc_pkg::ODCC_IDLE;
            end
            odcc_pkg::ODCC_DCDC: begin
               // Only 8AH/8BH are meaningful; other bytes are dropped
               if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::DCDC_PARAM) begin
                  next_converterEnable = byteData[0];
               end
               next_state = odcc_pkg::ODCC_IDLE;
            end
            default: begin
               if (byteData == odcc_pkg::CMD_REF_CURRENT) begin
                  next_state = odcc_pkg::ODCC_REF;
               end else if (byteData == odcc_pkg::CMD_MUX) begin
                  next_state = odcc_pkg::ODCC_MUX;
               end else if (byteData == odcc_pkg::CMD_DCDC) begin
                  next_state = odcc_pkg::ODCC_DCDC;
               end else if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::CMD_REMAP) begin
                  next_columnReverse = byteData[0];
               end else if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::CMD_PAD_LAYOUT) begin
                  next_padsEvenRight = byteData[0];
               end else if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::CMD_ALL_ON) begin
                  next_forceAllOn = byteData[0];
               end else if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::CMD_INVERT) begin
                  next_invertDisplay = byteData[0];
               end else if ((byteData & odcc_pkg::MASK_LOW_BIT) == odcc_pkg::CMD_DISPLAY) begin
                  next_displayOn = byteData[0];
               end
            end
         endcase
      end
   end

   // Decoder state; an opener parks here for exactly one command byte
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= odcc_pkg::ODCC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Command settings; reset loads the power-on defaults
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trimEn             <= odcc_pkg::TRIM_EN_RST;
         refCurrentInternal <= odcc_pkg::REF_SRC_RST;
         resistorCode       <= odcc_pkg::RES_CODE_RST;
         columnReverse      <= 1'b0;
         padsEvenRight      <= 1'b0;
         forceAllOn         <= 1'b0;
         invertDisplay      <= 1'b0;
         muxN               <= odcc_pkg::MUX_RST;
         converterEnable    <= odcc_pkg::DCDC_RST;
         displayOn          <= 1'b0;
      end else begin
         trimEn             <= next_trimEn;
         refCurrentInternal <= next_refCurrentInternal;
         resistorCode       <= next_resistorCode;
         columnReverse      <= next_columnReverse;
         padsEvenRight      <= next_padsEvenRight;
         forceAllOn         <= next_forceAllOn;
         invertDisplay      <= next_invertDisplay;
         muxN               <= next_muxN;
         converterEnable    <= next_converterEnable;
         displayOn          <= next_displayOn;
      end
   end

   // Resistor lookup trails the stored code by one cycle
   always_comb begin
      case (resistorCode)
         2'h0:    next_resistorKohm = odcc_pkg::RES_K0;
         2'h1:    next_resistorKohm = odcc_pkg::RES_K1;
         2'h2:    next_resistorKohm = odcc_pkg::RES_K2;
         default: next_resistorKohm = odcc_pkg::RES_K3;
      endcase
   end

   // Registered so the kilohm output comes straight from a flop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         resistorKohm <= odcc_pkg::RES_K0;
      end else begin
         resistorKohm <= next_resistorKohm;
      end
   end

   // Trim gate; the synced strap wins so a parallel host never trims
   always_comb begin
      next_trimActive  = trimEn && !parSync;
      next_trimDown    = trim.down;
      next_trimPercent = trim.pct;
   end

   // Calculator sees the gated enable and the synced pads
   assign trim.trimOn  = trimActive;
   assign trim.padCode = padSync;

   // Trim outputs lag the gate by one cycle through the calculator
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trimActive  <= 1'b0;
         trimDown    <= 1'b0;
         trimPercent <= 6'h00;
      end else begin
         trimActive  <= next_trimActive;
         trimDown    <= next_trimDown;
         trimPercent <= next_trimPercent;
      end
   end

   // Derived modes follow the settings being stored, same cycle
   always_comb begin
      next_muxRatio       = 7'({1'b0, next_muxN} + 7'h01);
      next_sleepMode      = !next_displayOn;
      next_converterRun   = next_displayOn && next_converterEnable;
      next_externalSupply = next_displayOn && !next_converterEnable;
      next_pixelForceOn   = next_forceAllOn;
      next_pixelInvert    = next_invertDisplay && !next_forceAllOn;
   end

   // Derived mode registers; display off at reset means sleep
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         muxRatio       <= 7'h40;
         sleepMode      <= 1'b1;
         converterRun   <= 1'b0;
         externalSupply <= 1'b0;
         pixelForceOn   <= 1'b0;
         pixelInvert    <= 1'b0;
      end else begin
         muxRatio       <= next_muxRatio;
         sleepMode      <= next_sleepMode;
         converterRun   <= next_converterRun;
         externalSupply <= next_externalSupply;
         pixelForceOn   <= next_pixelForceOn;
         pixelInvert    <= next_pixelInvert;
      end
   end

   // Column pointer wraps at 127; no load command lives in this block
   always_comb begin
      next_columnAddr = columnAddr;
      if (dataAccess) begin
         next_columnAddr = 7'(columnAddr + 7'h01);
      end
   end

   // Column pointer register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         columnAddr <= odcc_pkg::COL_RST;
      end else begin
         columnAddr <= next_columnAddr;
      end
   end
endmodule : odcc_config

// file: src/odcc_trim_calc.sv
`timescale 1ns/10ps
// Turns pad code into signed percent trim; pure combinational
module odcc_trim_calc (
   // Trim link
   odcc_trim_if.calc t
);
   logic [3:0] step;
   logic [5:0] mag;

   // Step magnitude, all-ones down code maps to zero
   always_comb begin
      step = t.padCode[3:0];
      mag  = 6'(step) * 6'(odcc_pkg::STEP_PCT);
      if (!t.trimOn) begin
         t.down = 1'b0;
         t.pct  = 6'h00;
      end else if (t.padCode[4] && step == odcc_pkg::STEP_ALL) begin
         t.down = 1'b0;
         t.pct  = 6'h00;
      end else begin
         t.down = t.padCode[4];
         t.pct  = mag;
      end
   end
endmodule : odcc_trim_calc

// file: testbench/odcc_config_checker.sv
`timescale 1ns/10ps
// Watches decoder ports; pend mirrors the two-byte opener awaiting its parameter
module odcc_config_checker (
   // Clock, reset and host stream
   input wire logic       mclk, resetn, byteValid, dataSel, dataAccess, parallelHost,
   input wire logic [7:0] byteData,
   // Settings and derived modes
   input wire logic       refCurrentInternal, trimActive, columnReverse, forceAllOn,
   input wire logic       invertDisplay, converterEnable, displayOn, sleepMode,
   input wire logic       converterRun, externalSupply, pixelForceOn, pixelInvert,
   input wire logic [1:0] resistorCode,
   input wire logic [9:0] resistorKohm,
   input wire logic [5:0] trimPercent,
   input wire logic [6:0] muxRatio, columnAddr
);
   logic       take;
   logic [7:0] pend, next_pend;
   assign take = byteValid && !dataSel;
   // Openers arm pend only from idle, so a parameter byte never re-arms it
   always_comb begin
      next_pend = 8'h00;
      if (pend == 8'h00 && (byteData == 8'h82 || byteData == 8'hA8 || byteData == 8'hAD)) begin
         next_pend = byteData;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend <= 8'h00;
      end else if (take) begin
         pend <= next_pend;
      end
   end
   // Resistor code to kilohm, as the decoder should report it
   function automatic logic [9:0] kohm(input logic [1:0] c);
      return (c == 2'h0) ? 10'h1FE : (c == 2'h1) ? 10'h136 : (c == 2'h2) ? 10'h0DC : 10'h0B4;
   endfunction : kohm
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   ref_select_a: assert property (take && pend == 8'h82 |=>
      refCurrentInternal == $past(byteData[2]) && resistorCode == $past(byteData[1:0]))
      else $error("reference select wrong");
   resistor_kohm_a: assert property (resistorKohm == kohm($past(resistorCode)))
      else $error("kilohm value wrong");
   trim_off_a: assert property (!trimActive [*2] |-> trimPercent == 6'h00)
      else $error("trim not zero");
   parallel_off_a: assert property (parallelHost [*4] |=> !trimActive)
      else $error("trim with parallel host");
   column_rev_a: assert property (take && pend == 8'h00 && byteData[7:1] == 7'h50 |=>
      columnReverse == $past(byteData[0])) else $error("column reverse wrong");
   force_priority_a: assert property (forceAllOn |-> pixelForceOn && !pixelInvert)
      else $error("force all on lost");
   invert_pixel_a: assert property (!forceAllOn |-> pixelInvert == invertDisplay)
      else $error("inversion wrong");
   mux_ratio_a: assert property (take && pend == 8'hA8 |=>
      muxRatio == {1'b0, $past(byteData[5:0])} + 7'h01) else $error("mux ratio wrong");
   conv_set_a: assert property (take && pend == 8'hAD && byteData[7:1] == 7'h45 |=>
      converterEnable == $past(byteData[0])) else $error("converter enable wrong");
   power_mode_a: assert property (sleepMode == !displayOn &&
      converterRun == (displayOn && converterEnable) &&
      externalSupply == (displayOn && !converterEnable)) else $error("power mode wrong");
   param_slot_a: assert property (take && pend != 8'h00 |=> $stable(displayOn))
      else $error("parameter decoded as command");
   data_ignored_a: assert property (byteValid && dataSel |=>
      $stable({displayOn, muxRatio, converterEnable, forceAllOn, invertDisplay}))
      else $error("data byte changed setting");
   column_step_a: assert property (dataAccess |=> columnAddr == $past(columnAddr) + 7'h01)
      else $error("column address step wrong");
   cover property (take && pend == 8'h82);
   cover property (take && pend == 8'hA8);
   cover property (converterRun);
   cover property (pixelForceOn && invertDisplay);
endmodule : odcc_config_checker
bind odcc_config odcc_config_checker i_chk (.mclk, .resetn, .byteValid, .dataSel, .dataAccess,
   .parallelHost, .byteData, .refCurrentInternal, .trimActive, .columnReverse, .forceAllOn,
   .invertDisplay, .converterEnable, .displayOn, .sleepMode, .converterRun, .externalSupply,
   .pixelForceOn, .pixelInvert, .resistorCode, .resistorKohm, .trimPercent, .muxRatio,
   .columnAddr);

// file: testbench/odcc_host_model.sv
`timescale 1ns/10ps
// Host processor side: bytes and access pulses move on falling edges
module odcc_host_model (
   // Clock
   input  wire logic       mclk,
   // Byte stream to the device
   output logic            byteValid,
   output logic [7:0]      byteData,
   output logic            dataSel,
   output logic            dataAccess
);
   // Bus quiet until the first byte
   initial begin
      byteValid  = 1'b0;
      byteData   = 8'h00;
      dataSel    = 1'b0;
      dataAccess = 1'b0;
   end
   // Strobe stays high across back-to-back bytes, no double assignment
   task automatic put(input logic s, input logic [7:0] b);
      byteValid = 1'b1;
      dataSel = s;
      byteData = b;
      @(negedge mclk);
   endtask : put
   // Released bus inverts the byte it holds, so two idles in a row show the last byte again
   task automatic idle(input int n);
      byteValid = 1'b0;
      byteData = ~byteData;
      repeat (n) @(negedge mclk);
   endtask : idle
   // Converter changed only with display off, then display on
   task automatic conv(input logic en);
      put(1'b0, 8'hAE);
      put(1'b0, 8'hAD);
      put(1'b0, {7'h45, en});
      put(1'b0, 8'hAF);
      idle(2);
   endtask : conv
   // One RAM data access
   task automatic access();
      dataAccess = 1'b1;
      @(negedge mclk);
      dataAccess = 1'b0;
      @(negedge mclk);
   endtask : access
endmodule : odcc_host_model

// file: testbench/oled_display_config_commands_bench.sv
`timescale 1ns/10ps
// Command-stream bench for the configuration decoder
module oled_display_config_commands_bench;
   logic       mclk = 1'b0, resetn = 1'b0, parallelHost;
   logic [4:0] trimPads;
   logic       byteValid, dataSel, dataAccess, refCurrentInternal, trimActive, trimDown;
   logic       columnReverse, padsEvenRight, forceAllOn, invertDisplay, converterEnable;
   logic       displayOn, sleepMode, converterRun, externalSupply, pixelForceOn, pixelInvert;
   logic [7:0] byteData;
   logic [1:0] resistorCode;
   logic [9:0] resistorKohm;
   logic [5:0] trimPercent;
   logic [6:0] muxRatio, columnAddr;
   int         err_count = 0, comparisons = 0;
   always #4 mclk = ~mclk;
   odcc_host_model i_host (.mclk, .byteValid, .byteData, .dataSel, .dataAccess);
   odcc_config i_dut (.mclk, .resetn, .byteValid, .byteData, .dataSel, .dataAccess,
      .parallelHost, .trimPads, .refCurrentInternal, .resistorCode, .resistorKohm,
      .trimActive, .trimDown, .trimPercent, .columnReverse, .padsEvenRight, .forceAllOn,
      .invertDisplay, .muxRatio, .converterEnable, .displayOn, .sleepMode, .converterRun,
      .externalSupply, .pixelForceOn, .pixelInvert, .columnAddr);
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask : chk
   task automatic end_of_test();
      if (err_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   // Opener and parameter back to back; two idle edges cover the slower outputs
   task automatic cmd(input logic [7:0] op, input logic [7:0] p, input logic two);
      i_host.put(1'b0, op);
      if (two) i_host.put(1'b0, p);
      i_host.idle(2);
   endtask : cmd
   // Hang guard
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
   initial begin
      logic [9:0] kk [4];
      logic [3:0] m;
      kk = '{10'h1FE, 10'h136, 10'h0DC, 10'h0B4};
      m = 4'h0;
      parallelHost = 1'b0;
      trimPads = 5'h00;
      repeat (8) @(negedge mclk);
      resetn = 1'b1;
      chk({refCurrentInternal, resistorKohm}, 12'h1FE);
      chk({trimActive, muxRatio, converterEnable, displayOn, sleepMode}, 12'h205);
      chk({columnReverse, padsEvenRight, forceAllOn, invertDisplay, columnAddr}, 12'h0);
      for (int i = 0; i < 4; i++) begin
         cmd(8'h82, {6'h01, i[1:0]}, 1'b1);
         chk({refCurrentInternal, resistorCode}, {1'b1, i[1:0]});
         chk(resistorKohm, kk[i]);
      end
      // Contrast at midscale before pad trim
      i_host.put(1'b0, 8'h81);
      i_host.put(1'b0, 8'h80);
      trimPads = 5'h09;
      cmd(8'h82, 8'h80, 1'b1);
      i_host.idle(4);
      chk({refCurrentInternal, trimActive, trimDown, trimPercent}, 12'h09B);
      trimPads = 5'h1F;
      i_host.idle(4);
      chk(trimPercent, 6'h00);
      trimPads = 5'h1E;
      i_host.idle(4);
      chk({trimDown, trimPercent}, 7'h6A);
      parallelHost = 1'b1;
      i_host.idle(5);
      chk({trimActive, trimPercent}, 7'h00);
      // Set then clear the four single-bit modes; A6 last so inversion meets force
      for (int j = 0; j < 8; j++) begin
         m[3 - j % 4] = (j < 4);
         cmd({5'h14, j[1:0], m[3 - j % 4]}, 8'h00, 1'b0);
         chk({columnReverse, padsEvenRight, forceAllOn, invertDisplay}, m);
         if (j == 3) chk({pixelForceOn, pixelInvert}, 2'b10);
         if (j == 6) chk({pixelForceOn, pixelInvert}, 2'b01);
      end
      cmd(8'hA8, 8'hC0, 1'b1);
      chk(muxRatio, 7'h01);
      cmd(8'hA8, 8'h1F, 1'b1);
      chk(muxRatio, 7'h20);
      cmd(8'hA8, 8'hAF, 1'b1);
      chk({muxRatio, displayOn}, 8'h60);
      i_host.put(1'b1, 8'hAF);
      i_host.idle(2);
      chk(displayOn, 1'b0);
      i_host.conv(1'b0);
      chk({converterEnable, displayOn, sleepMode, converterRun, externalSupply}, 5'h09);
      cmd(8'hAE, 8'h00, 1'b0);
      cmd(8'hAD, 8'h55, 1'b1);
      chk({converterEnable, sleepMode}, 2'b01);
      i_host.conv(1'b1);
      chk({converterEnable, displayOn, sleepMode, converterRun, externalSupply}, 5'h1A);
      repeat (3) i_host.access();
      chk(columnAddr, 7'h03);
      // Mid-run reset must bring every changed setting back to its default
      resetn = 1'b0;
      i_host.idle(2);
      resetn = 1'b1;
      chk({trimActive, muxRatio, converterEnable, displayOn, sleepMode}, 12'h205);
      chk({columnReverse, padsEvenRight, forceAllOn, invertDisplay, columnAddr}, 12'h0);
      end_of_test();
   end
endmodule : oled_display_config_commands_bench
